// *** pdn_decode.sv ***
/*
  Power-down decoder: combines the individual power-down bits with the
  global shutdown bit, gated by the mask except for channel A, registering each enable.
  Assumes register values arrive on the same clock.
*/
module pdn_decode
  import pdn_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  pdn_regs_if.decode r
);
  typedef struct packed {
    logic clk_pd;
    logic ref_pd;
    logic cha_pd;
    logic bias_pd;
    logic bg_pd;
  } dec_state_type;
  dec_state_type st_q, st_d;
  logic glob;
  always_comb begin
    glob = r.ctrl[BIT_GLOBAL_SHUTDOWN];
    st_d.clk_pd = r.ctrl[BIT_SAMPLE_CLOCK_BUFFER_OFF] | (glob & ~r.mask[BIT_KEEP_CLOCK_BUFFER_ON]);
    st_d.ref_pd = r.ctrl[BIT_REFERENCE_AMPLIFIER_OFF] | (glob & ~r.mask[BIT_KEEP_REFERENCE_AMP_ON]);
    st_d.cha_pd = r.ctrl[BIT_CHANNEL_A_OFF] | glob;
    st_d.bias_pd = glob & ~r.mask[BIT_KEEP_CHANNEL_BIAS_ON];
    st_d.bg_pd = glob & r.mask[BIT_ALLOW_BANDGAP_OFF];
  end
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
  assign r.sample_clock_buffer_pd = st_q.clk_pd;
  assign r.reference_amplifier_pd = st_q.ref_pd;
  assign r.channel_a_pd = st_q.cha_pd;
  assign r.channel_bias_pd = st_q.bias_pd;
  assign r.bandgap_pd = st_q.bg_pd;
endmodule

// *** pdn_pkg.sv ***
/*
  Shared constants for the power-down and output-buffer register bank:
  register offsets, field positions and reset values.
  Assumes an 8-bit register port with 8-bit addresses.
*/
package pdn_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [7:0] OFF_POWER_DOWN_CONTROL = 8'h08;
  localparam logic [7:0] OFF_OUTPUT_BUFFER_DISABLE_LOW = 8'h0a;
  localparam logic [7:0] OFF_OUTPUT_BUFFER_DISABLE_MID = 8'h0b;
  localparam logic [7:0] OFF_OUTPUT_BUFFER_DISABLE_HIGH = 8'h0c;
  localparam logic [7:0] OFF_GLOBAL_POWER_DOWN_MASK = 8'h0d;
  // Power-down control fields
  localparam int BIT_SAMPLE_CLOCK_BUFFER_OFF = 5;
  localparam int BIT_REFERENCE_AMPLIFIER_OFF = 4;
  localparam int BIT_CHANNEL_A_OFF = 2;
  localparam int BIT_MUST_ONE = 1;
  localparam int BIT_GLOBAL_SHUTDOWN = 0;
  // Mask fields
  localparam int BIT_KEEP_CHANNEL_BIAS_ON = 5;
  localparam int BIT_KEEP_CLOCK_BUFFER_ON = 3;
  localparam int BIT_KEEP_REFERENCE_AMP_ON = 2;
  localparam int BIT_ALLOW_BANDGAP_OFF = 1;
  // Reset values
  localparam logic [7:0] RST_POWER_DOWN_CONTROL = 8'h02;
  localparam logic [7:0] RST_OUTPUT_BUFFER_DISABLE = 8'h00;
  localparam logic [7:0] RST_GLOBAL_POWER_DOWN_MASK = 8'h00;
  localparam int OB_W = 24;
endpackage

// *** pdn_regs.sv ***
/*
  Power-down and output-buffer register bank, written and read through the
  device's serial control port decoder as simple address/write/read strobes.
  Assumes the port decoder delivers one-cycle strobes on mclk.
*/
// Functional notes
// - Power control bit 5 switches off the sampling clock input buffer.
// - Power control bit 4 switches off the reference gain amplifier.
// - Power control bit 2 powers down channel A.
// - Power control bit 0 enters global power-down, gated by mask at 0x0D.
// - Mask fields at bits 5, 3, 2, 1; all bits reset to zero.
// - 24-bit output buffer disable over three registers; one disables, reset zero.
// - Clock, amplifier, bias masks: zero allows power-down, one keeps powered.
// - Bandgap mask inverted: one allows bandgap off, zero keeps it on.
module pdn_regs
  import pdn_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  output logic [OB_W-1:0] output_buffer_off,
  output logic sample_clock_buffer_off,
  output logic reference_amplifier_off,
  output logic channel_a_off,
  output logic channel_bias_off,
  output logic bandgap_off
);
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] ob_low;
    logic [7:0] ob_mid;
    logic [7:0] ob_high;
    logic [7:0] mask;
    logic [7:0] rdata;
  } bank_state_type;
  bank_state_type st_q, st_d;
  pdn_regs_if rif ();

  function automatic logic [7:0] read_mux(input logic [7:0] a, input bank_state_type s);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      OFF_POWER_DOWN_CONTROL: v = s.ctrl;
      OFF_OUTPUT_BUFFER_DISABLE_LOW: v = s.ob_low;
      OFF_OUTPUT_BUFFER_DISABLE_MID: v = s.ob_mid;
      OFF_OUTPUT_BUFFER_DISABLE_HIGH: v = s.ob_high;
      OFF_GLOBAL_POWER_DOWN_MASK: v = s.mask;
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  always_comb begin
    st_d = st_q;
    if (reg_wr) begin
      case (reg_addr)
        OFF_POWER_DOWN_CONTROL: st_d.ctrl = reg_wdata;
        OFF_OUTPUT_BUFFER_DISABLE_LOW: st_d.ob_low = reg_wdata;
        OFF_OUTPUT_BUFFER_DISABLE_MID: st_d.ob_mid = reg_wdata;
        OFF_OUTPUT_BUFFER_DISABLE_HIGH: st_d.ob_high = reg_wdata;
        OFF_GLOBAL_POWER_DOWN_MASK: st_d.mask = reg_wdata;
        default: st_d = st_q;
      endcase
    end
    if (reg_rd) begin
      st_d.rdata = read_mux(reg_addr, st_q);
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      st_q.ctrl <= RST_POWER_DOWN_CONTROL;
      st_q.ob_low <= RST_OUTPUT_BUFFER_DISABLE;
      st_q.ob_mid <= RST_OUTPUT_BUFFER_DISABLE;
      st_q.ob_high <= RST_OUTPUT_BUFFER_DISABLE;
      st_q.mask <= RST_GLOBAL_POWER_DOWN_MASK;
      st_q.rdata <= 8'h00;
    end else begin
      st_q <= st_d;
    end
  end

  assign rif.ctrl = st_q.ctrl;
  assign rif.mask = st_q.mask;

  pdn_decode u_decode (
    .mclk(mclk),
    .rstn(rstn),
    .r(rif)
  );

  assign reg_rdata = st_q.rdata;
  // Only the 24 data-pin buffers; clock buffers are controlled elsewhere
  assign output_buffer_off = {st_q.ob_high, st_q.ob_mid, st_q.ob_low};
  assign sample_clock_buffer_off = rif.sample_clock_buffer_pd;
  assign reference_amplifier_off = rif.reference_amplifier_pd;
  assign channel_a_off = rif.channel_a_pd;
  assign channel_bias_off = rif.channel_bias_pd;
  assign bandgap_off = rif.bandgap_pd;
endmodule

// *** pdn_regs_chk.sv ***
/* Port checker for the power-down register bank; assumes it is bound onto pdn_regs. */
module pdn_regs_chk (
  input logic mclk, rstn, reg_wr, reg_rd, sample_clock_buffer_off, reference_amplifier_off,
  input logic channel_a_off, channel_bias_off, bandgap_off,
  input logic [7:0] reg_addr, reg_wdata, reg_rdata
);
  timeunit 1ns / 1ps;
  logic [7:0] c_q, m_q;
  wire [4:0] f = {c_q[5] | c_q[0] & ~m_q[3], c_q[4] | c_q[0] & ~m_q[2], c_q[2] | c_q[0],
    c_q[0] & ~m_q[5], c_q[0] & m_q[1]};
  always_ff @(posedge mclk) begin
    c_q <= !rstn ? 8'h02 : reg_wr && reg_addr == 8'h08 ? reg_wdata : c_q;
    m_q <= !rstn ? 8'h00 : reg_wr && reg_addr == 8'h0d ? reg_wdata : m_q;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  property p_ck; sample_clock_buffer_off == $past(f[4]); endproperty
  a_ck: assert property (p_ck) else $error("clock buffer");
  property p_ra; reference_amplifier_off == $past(f[3]); endproperty
  a_ra: assert property (p_ra) else $error("amplifier");
  property p_ch; channel_a_off == $past(f[2]); endproperty
  a_ch: assert property (p_ch) else $error("channel");
  property p_bi; channel_bias_off == $past(f[1]); endproperty
  a_bi: assert property (p_bi) else $error("bias");
  property p_bg; bandgap_off == $past(f[0]); endproperty
  a_bg: assert property (p_bg) else $error("bandgap");
  property p_rc; reg_rd && reg_addr == 8'h08 |=> reg_rdata == $past(c_q); endproperty
  a_rc: assert property (p_rc) else $error("control read");
  property p_rm; reg_rd && reg_addr == 8'h0d |=> reg_rdata == $past(m_q); endproperty
  a_rm: assert property (p_rm) else $error("mask read");
  property p_rz; reg_rd && !(reg_addr inside {8'h08, [8'h0a:8'h0d]}) |=> reg_rdata == 8'h00; endproperty
  a_rz: assert property (p_rz) else $error("unmapped read");
endmodule
bind pdn_regs pdn_regs_chk chk_u (.*);

// *** pdn_regs_if.sv ***
/*
  Carrier between the register bank and its power-down decoder.
  Assumes both ends run on the same clock.
*/
interface pdn_regs_if;
  logic [7:0] ctrl;
  logic [7:0] mask;
  logic sample_clock_buffer_pd;
  logic reference_amplifier_pd;
  logic channel_a_pd;
  logic channel_bias_pd;
  logic bandgap_pd;
  modport bank (output ctrl, output mask, input sample_clock_buffer_pd, input reference_amplifier_pd,
    input channel_a_pd, input channel_bias_pd, input bandgap_pd);
  modport decode (input ctrl, input mask, output sample_clock_buffer_pd, output reference_amplifier_pd,
    output channel_a_pd, output channel_bias_pd, output bandgap_pd);
endinterface

// *** tb.sv ***
/* Bench for pdn_regs; drives its strobe register port directly. */
module tb import pdn_pkg::*; ;
  timeunit 1ns / 1ps;
  logic mclk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, q [$];
  logic [23:0] output_buffer_off;
  logic sample_clock_buffer_off, reference_amplifier_off, channel_a_off, channel_bias_off, bandgap_off;
  logic [31:0] lfsr = 32'hcaa9d695;
  int n_errors = 0, check_count = 0;
  localparam logic [7:0] AD [6] = '{8'h08, 8'h0d, 8'h0a, 8'h0b, 8'h0c, 8'h0e};
  localparam logic [23:0] MD [4] = '{24'h0c1e60, 24'h0cfe7f, 24'hfcefff, 24'hfdefff};
  pdn_regs dut_u (.*);
  initial forever #20 mclk = ~mclk;
  function automatic logic [31:0] nx(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic bad(input string s);
    n_errors++;
    $display("mismatch at %0t: %s", $time, s);
  endtask
  task automatic summarize();
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic xfer(input logic [1:0] op, input logic [7:0] a, d, e);
    @(posedge mclk) #1 {reg_wr, reg_rd} = op;
    {reg_addr, reg_wdata} = {a, d};
    if (op[0]) q.push_back(e);
    @(posedge mclk) #1 {reg_wr, reg_rd} = 2'b00;
  endtask
  always @(posedge mclk) if (reg_rd) begin
    #2 check_count++;
    if (reg_rdata !== q[0]) bad("read data");
    q.delete(0);
  end
  initial begin
    for (int p = 0; p < 2; p++) begin
      rstn = 1'b0;
      repeat (8) @(posedge mclk);
      #1 rstn = 1'b1;
      for (int i = 0; i < 6; i++) xfer(2'b01, AD[i], 8'h00, i == 0 ? 8'h02 : 8'h00);
      xfer(2'b11, 8'h0d, 8'h2e, 8'h00);
      for (int i = 0; i < 60; i++) begin
        lfsr = nx(lfsr);
        xfer(2'b10, AD[lfsr[1:0]], lfsr[15:8], 8'h00);
        xfer(2'b01, AD[lfsr[1:0]], 8'h00, lfsr[15:8]);
      end
      for (int m = 0; m < 4; m++) begin
        for (int j = 0; j < 3; j++) xfer(2'b10, AD[j + 2], MD[m][8 * j +: 8], 8'h00);
        check_count++;
        if (output_buffer_off !== MD[m]) bad("buffer field");
      end
      $display("pass %0d done", p);
    end
    if (q.size() > 0) bad("timeout");
    summarize();
  end
endmodule
